// ==== dv/ca_checker.sv ====
`timescale 1ns/1ps
module ca_checker #(
   parameter int N = 5
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [N-1:0] pin_out,
   input wire logic [N-1:0] pin_oe,
   input wire logic irq,
   input wire logic wdt_reset
);
   logic wr_q;
   wire take = hsel & htrans[1] & hready & ce;
   wire rd_take = take & ~hwrite;
   // write data phase marker; registers change only at its closing edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) wr_q <= 1'b0;
      else if (ce) wr_q <= take & hwrite;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_wdt_end;
      ##1 !wdt_reset;
   endsequence
   AST_FREEZE: assert property (!ce |=> $stable(pin_out) && $stable(irq))
      else $error("state moved while ce low");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_q))
      else $error("irq dropped without a write");
   AST_IRQ_RISE: assert property ($rose(irq) |-> $past(ce))
      else $error("irq rose while frozen");
   AST_OE_WR: assert property ($changed(pin_oe) |-> $past(wr_q))
      else $error("pin_oe moved without a write");
   AST_PIN_MOVE: assert property ($changed(pin_out) |-> $past(ce) && $past(pin_oe) != '0)
      else $error("pin_out moved while not driving");
   AST_RD_HOLD: assert property ($changed(hrdata) |-> $past(rd_take))
      else $error("hrdata moved without a read");
   AST_WDT_ONE: assert property (wdt_reset && ce |-> s_wdt_end)
      else $error("wdt_reset longer than one cycle");
   AST_WDT_RUN: assert property ($rose(wdt_reset) |-> $past(ce))
      else $error("wdt_reset while frozen");
endmodule : ca_checker
bind counter_array ca_checker #(.N(N)) u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .wdt_reset(wdt_reset));

// ==== dv/pin_agent.sv ====
`timescale 1ns/1ps
module pin_agent #(
   parameter int N = 5
) (
   input wire logic [N-1:0] drv,
   input wire logic [N-1:0] pin_out,
   input wire logic [N-1:0] pin_oe,
   output logic [N-1:0] pin_in
);
   // block wins where it drives, else the outside source
   always_comb begin
      for (int i = 0; i < N; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : drv[i];
   end
endmodule : pin_agent

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
   import ca_pkg::*;
   logic clk, sys_rst, ce, hsel, hwrite, hreadyout, hresp, irq, wdt_reset;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [NUM_MOD-1:0] pin_in, pin_out, pin_oe, drv;
   int fails, total_checks, cyc, n;
   wire hready = hreadyout;
   counter_array u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq),
      .wdt_reset(wdt_reset));
   pin_agent u_pins (.drv(drv), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // reserved bits always written as zero
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic t_reset;
      for (int m = 0; m < NUM_MOD; m++) begin
         bus(1'b0, 8'(MODE_BASE + STRIDE * m), 32'h0);
         `CHK(r[6:0], MODE_RST)
      end
      bus(1'b0, CTRL_OFF, 32'h0);
      `CHK(r[6], 1'b0)
      `CHK(hresp, 1'b0)
      $display("reset test done");
   endtask : t_reset
   task automatic t_run;
      logic [15:0] c;
      bus(1'b1, CNT_OFF, 32'h1000);
      repeat (5) @(posedge clk);
      bus(1'b0, CNT_OFF, 32'h0);
      `CHK(r[15:0], 16'h1000)
      bus(1'b1, CTRL_OFF, 32'h40);
      bus(1'b0, CNT_OFF, 32'h0);
      c = r[15:0];
      bus(1'b0, CNT_OFF, 32'h0);
      `CHK(r[15:0] !== c, 1'b1)
      bus(1'b1, CTRL_OFF, 32'h0);
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      bus(1'b0, CNT_OFF, 32'h0);
      c = r[15:0];
      repeat (4) @(posedge clk);
      bus(1'b0, CNT_OFF, 32'h0);
      `CHK(r[15:0], c)
      $display("run test done");
   endtask : t_run
   task automatic t_cap;
      logic [7:0] md [3] = '{8'h21, 8'h10, 8'h30};
      logic [15:0] e;
      bus(1'b1, IMASK_OFF, 32'h01);
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, 8'(MODE_BASE + STRIDE * m), {24'h0, md[m]});
         e = (m == 1) ? 16'h0 : 16'h1100 + 16'(m);
         bus(1'b1, CNT_OFF, 32'h1100 + m);
         drv[m] <= 1'b1;
         repeat (8) @(posedge clk);
         bus(1'b0, 8'(CAP_BASE + STRIDE * m), 32'h0);
         `CHK(r[15:0], e)
         if (m != 0) e = 16'h2200 + 16'(m);
         bus(1'b1, CNT_OFF, 32'h2200 + m);
         drv[m] <= 1'b0;
         repeat (8) @(posedge clk);
         bus(1'b0, 8'(CAP_BASE + STRIDE * m), 32'h0);
         `CHK(r[15:0], e)
      end
      bus(1'b0, CTRL_OFF, 32'h0);
      `CHK(r[2:0], 3'b111)
      `CHK(irq, 1'b1)
      bus(1'b1, CTRL_OFF, 32'h07);
      @(posedge clk);
      `CHK(irq, 1'b0)
      $display("capture test done");
   endtask : t_cap
   task automatic t_tog;
      bus(1'b1, 8'(CAP_BASE + STRIDE * 3), 32'h0010);
      bus(1'b1, 8'(MODE_BASE + STRIDE * 3), 32'h4C);
      bus(1'b1, CNT_OFF, 32'h0);
      bus(1'b1, CTRL_OFF, 32'h40);
      repeat (40) @(posedge clk);
      bus(1'b1, CTRL_OFF, 32'h0);
      `CHK(pin_oe[3], 1'b1)
      `CHK(pin_out[3], 1'b1)
      bus(1'b0, CTRL_OFF, 32'h0);
      `CHK(r[3], 1'b1)
      $display("toggle test done");
   endtask : t_tog
   task automatic t_pwm;
      bus(1'b1, CAP_BASE, 32'h8080);
      bus(1'b1, MODE_BASE, 32'h42);
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, CNT_OFF, 32'h7F + k);
         repeat (3) @(posedge clk);
         `CHK(pin_oe[0], 1'b1)
         `CHK(pin_out[0], k[0])
      end
      $display("pwm test done");
   endtask : t_pwm
   task automatic t_wdt;
      bus(1'b1, CMODE_OFF, 32'h40);
      bus(1'b1, 8'(CAP_BASE + STRIDE * 4), 32'h20);
      bus(1'b1, 8'(MODE_BASE + STRIDE * 4), 32'h48);
      bus(1'b1, CNT_OFF, 32'h0);
      bus(1'b1, CTRL_OFF, 32'h40);
      n = 0;
      repeat (80) begin
         @(posedge clk);
         if (wdt_reset === 1'b1) n++;
      end
      bus(1'b1, CTRL_OFF, 32'h0);
      `CHK(n, 1)
      $display("watchdog test done");
   endtask : t_wdt
   task automatic t_rst2;
      bus(1'b1, 8'(MODE_BASE + STRIDE), 32'h4C);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, 8'(MODE_BASE + STRIDE), 32'h0);
      `CHK(r[6:0], MODE_RST)
      `CHK(pin_oe[1], 1'b0)
      $display("mid-run reset test done");
   endtask : t_rst2
   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      drv = '0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_run();
      t_cap();
      t_tog();
      t_pwm();
      t_wdt();
      t_rst2();
      close_out();
   end
endmodule : tb_top

// ==== rtl/ca_pkg.sv ====
package ca_pkg;
   // module count and widths
   localparam int NUM_MOD = 5;
   localparam int CNT_W = 16;
   localparam int MODE_W = 7;
   localparam int WDT_MOD = 4;
   localparam int SYNC_STAGES = 3;

   // register byte offsets (one word each)
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] CMODE_OFF = 8'h04;
   localparam logic [7:0] CNT_OFF = 8'h08;
   localparam logic [7:0] IMASK_OFF = 8'h0C;
   localparam logic [7:0] MODE_BASE = 8'h10;
   localparam logic [7:0] CAP_BASE = 8'h30;
   localparam logic [7:0] STRIDE = 8'h04;

   // counter_array_control fields
   localparam int CTRL_OVF_BIT = 7;
   localparam int CTRL_RUN_BIT = 6;
   // counter mode fields
   localparam int CMODE_WDT_BIT = 6;

   // module_mode_select fields
   localparam int M_ECOM = 6;
   localparam int M_CAPP = 5;
   localparam int M_CAPN = 4;
   localparam int M_MAT = 3;
   localparam int M_TOG = 2;
   localparam int M_PWM = 1;
   localparam int M_ECCF = 0;

   // reset values and counter limits
   localparam logic [MODE_W-1:0] MODE_RST = 7'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [7:0] LOW_MAX = 8'hFF;
   localparam logic [7:0] IMASK_RST = 8'h00;
endpackage : ca_pkg

// ==== rtl/counter_array.sv ====
// Operation
// - The shared counter advances only while counter_run is set.
// - Event flags are set by hardware only and cleared only by a software write.
// - With match_flag_enable set, a counter/compare match sets the event flag.
// - Rise capture alone latches the 16-bit counter on a rising pin edge.
// - Fall capture alone latches the 16-bit counter on a falling pin edge.
// - Both capture enables capture on either pin edge.
// - Compare, match and toggle enables make each match invert the pin.
// - Unimplemented bits read as an undefined value and nothing relies on it.
// - Reset clears the seven defined bits of each mode register.
// - A capture copies both counter bytes into the module's capture bytes.
// - Compare plus match enable gives a 16-bit software timer flagging each match.
// - Pulse-width output is low while the low counter byte is below duty, high otherwise.
// - Watchdog enable with module four in compare mode raises internal reset on match.
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module counter_array
   import ca_pkg::*;
#(
   parameter int N = NUM_MOD
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [N-1:0] pin_in,
   output logic [N-1:0] pin_out,
   output logic [N-1:0] pin_oe,
   output logic irq,
   output logic wdt_reset
);
   // bus state
   logic [7:0] a_q;
   logic wr_q;
   logic [31:0] rdata_q;

   // control state
   logic run_q;
   logic ovf_q;
   logic watchdog_enable_q;
   logic [7:0] imask_q;
   logic [N-1:0] flag_q;
   logic [N-1:0] flag_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic wdt_q;

   // per-module state
   logic [MODE_W-1:0] mode_q [N];
   logic [CNT_W-1:0] cap_q [N];
   logic [N-1:0] out_q;

   // per-module combinational
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   logic [N-1:0] match;
   logic [N-1:0] flag_set;
   logic [N-1:0] eccf;
   logic [N-1:0] mode_sel;
   logic [N-1:0] cap_sel;
   logic [N-1:0] pwm_on;

   // address phase and write strobes
   wire take = hsel & htrans[1] & hready & ce;
   wire wr_act = wr_q & ce;
   wire ctrl_wr = wr_act && a_q == CTRL_OFF;
   wire cmode_wr = wr_act && a_q == CMODE_OFF;
   wire cnt_wr = wr_act && a_q == CNT_OFF;
   wire imask_wr = wr_act && a_q == IMASK_OFF;

   // counter
   wire tick = ce & run_q;
   wire wrap = tick && cnt_q == CNT_MAX;
   wire low_wrap = tick && cnt_q[7:0] == LOW_MAX;

   // zero wait states; a low clock enable stalls the bus instead of dropping transfers
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // data phase marker for writes; reads are answered from the address phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q <= 1'b0;
      end else if (ce) begin
         wr_q <= take & hwrite;
      end
   end

   // address held for the data phase, when hwdata finally stands
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         a_q <= 8'h00;
      end else if (take) begin
         a_q <= haddr[7:0];
      end
   end

   // read mux, evaluated in the address phase
   logic [31:0] rd_mux;
   wire [7:0] ra = haddr[7:0];
   wire [7:0] ra_mode = ra - MODE_BASE;
   wire [7:0] ra_cap = ra - CAP_BASE;
   wire [5:0] ri_mode = ra_mode[7:2];
   wire [5:0] ri_cap = ra_cap[7:2];
   wire rd_mode = ra >= MODE_BASE && ri_mode < 6'(N) && ra_mode[1:0] == 2'b00;
   wire rd_cap = ra >= CAP_BASE && ri_cap < 6'(N) && ra_cap[1:0] == 2'b00;
   wire [7:0] ctrl_rd = {ovf_q, run_q, 1'b0, 5'(flag_q)};
   wire [31:0] cmode_rd = 32'(watchdog_enable_q) << CMODE_WDT_BIT;
   wire rd_ctrl = ra == CTRL_OFF;
   wire rd_cmode = ra == CMODE_OFF;
   wire rd_cnt = ra == CNT_OFF;
   wire rd_imask = ra == IMASK_OFF;

   // reserved bits read back as zero here, but software must not count on it
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (rd_ctrl) begin
         rd_mux = {24'h000000, ctrl_rd};
      end else if (rd_cmode) begin
         rd_mux = cmode_rd;
      end else if (rd_cnt) begin
         rd_mux = {16'h0000, cnt_q};
      end else if (rd_imask) begin
         rd_mux = {24'h000000, imask_q};
      end else if (rd_mode) begin
         rd_mux = {25'h0000000, mode_q[ri_mode[2:0]]};
      end else if (rd_cap) begin
         rd_mux = {16'h0000, cap_q[ri_cap[2:0]]};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (take & ~hwrite) begin
         rdata_q <= rd_mux;
      end
   end

   // control, counter mode and mask registers; every write strobe already carries ce
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_q <= 1'b0;
      end else if (ctrl_wr) begin
         run_q <= hwdata[CTRL_RUN_BIT];
      end
   end

   // watchdog enable lives alone in the counter mode word
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         watchdog_enable_q <= 1'b0;
      end else if (cmode_wr) begin
         watchdog_enable_q <= hwdata[CMODE_WDT_BIT];
      end
   end

   // mask bits line up with the control word
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         imask_q <= IMASK_RST;
      end else if (imask_wr) begin
         imask_q <= hwdata[7:0];
      end
   end

   // bit 7 of a mode word is not stored, so it reads back as zero
   wire [MODE_W-1:0] mode_wd = hwdata[MODE_W-1:0];

   // a software write takes priority over an advance in the same cycle
   wire [CNT_W-1:0] cnt_inc = cnt_q + 16'h0001;
   wire [CNT_W-1:0] cnt_wd = hwdata[CNT_W-1:0];

   always_comb begin
      cnt_d = cnt_q;
      if (cnt_wr) begin
         cnt_d = cnt_wd;
      end else if (tick) begin
         cnt_d = cnt_inc;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= CNT_RST;
      end else if (ce) begin
         cnt_q <= cnt_d;
      end
   end

   // sticky flags: write one clears, a hardware set in the same cycle wins
   wire [N-1:0] flag_clr = ctrl_wr ? hwdata[N-1:0] : '0;
   wire ovf_clr = ctrl_wr & hwdata[CTRL_OVF_BIT];
   wire ovf_d = (ovf_q & ~ovf_clr) | wrap;
   assign flag_d = (flag_q & ~flag_clr) | flag_set;

   // module flags
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_q <= '0;
      end else if (ce) begin
         flag_q <= flag_d;
      end
   end

   // overflow shares the control word but is kept apart from the module flags
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovf_q <= 1'b0;
      end else if (ce) begin
         ovf_q <= ovf_d;
      end
   end

   // per-module logic
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_mod
         wire [7:0] mo = MODE_BASE + 8'(i * 4);
         wire [7:0] co = CAP_BASE + 8'(i * 4);
         wire ecom = mode_q[i][M_ECOM];
         wire capp = mode_q[i][M_CAPP];
         wire capn = mode_q[i][M_CAPN];
         wire mat = mode_q[i][M_MAT];
         wire tog = mode_q[i][M_TOG];
         wire pwm = mode_q[i][M_PWM];
         wire cap_mode = ~mat & ~tog & ~pwm;
         // one named wire per capture, high-speed output and PWM mode of the table
         wire cap_rise_only = cap_mode & capp & ~capn;
         wire cap_fall_only = cap_mode & ~capp & capn;
         wire cap_both = cap_mode & capp & capn;
         wire hs_out = ecom & mat & tog & ~pwm & ~capp & ~capn;
         wire pwm8 = ecom & pwm;
         wire take_rise = (cap_rise_only | cap_both) & rise[i];
         wire take_fall = (cap_fall_only | cap_both) & fall[i];
         // capture on either edge needs both enables
         wire cap_go = take_rise | take_fall;
         wire tog_go = hs_out & match[i];
         // duty is the low byte, its reload value the high byte
         wire [7:0] duty = cap_q[i][7:0];
         wire [7:0] reload = cap_q[i][15:8];
         wire pwm_hi = cnt_q[7:0] >= duty;
         wire reload_go = pwm8 & low_wrap;
         logic o_q;


         pin_edge_sync u_sync (
            .clk(clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .pin(pin_in[i]),
            .rise(rise[i]),
            .fall(fall[i])
         );

         assign mode_sel[i] = wr_act && a_q == mo;
         assign cap_sel[i] = wr_act && a_q == co;
         // compare only while counting, so a stopped counter never flags a match
         assign match[i] = ecom & tick & (cnt_q == cap_q[i]);
         // a capture and a match both count as the module's event
         wire match_evt = mat & ~pwm & match[i];
         assign flag_set[i] = cap_go | match_evt;
         assign eccf[i] = mode_q[i][M_ECCF];
         assign pwm_on[i] = pwm8;
         assign pin_oe[i] = pwm_on[i] | hs_out;

         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               mode_q[i] <= MODE_RST;
            end else if (ce && mode_sel[i]) begin
               mode_q[i] <= mode_wd;
            end
         end

         // a capture beats a software write in the same cycle
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               cap_q[i] <= CNT_RST;
            end else if (ce) begin
               if (cap_go) begin
                  cap_q[i] <= cnt_q;
               end else if (cap_sel[i]) begin
                  cap_q[i] <= cnt_wd;
               end else if (reload_go) begin
                  // reload at wrap keeps the duty change glitch free
                  cap_q[i][7:0] <= reload;
               end
            end
         end

         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               o_q <= 1'b0;
            end else if (ce) begin
               if (pwm_on[i]) begin
                  o_q <= pwm_hi;
               end else if (tog_go) begin
                  o_q <= ~o_q;
               end
            end
         end

         assign out_q[i] = o_q;
      end
   endgenerate

   assign pin_out = out_q;

   // watchdog: module four in a compare mode
   wire wd_mode = watchdog_enable_q & mode_q[WDT_MOD][M_ECOM] & ~mode_q[WDT_MOD][M_PWM];
   // the match already needs a counting cycle, so a stopped counter never fires
   wire wdt_hit = wd_mode & match[WDT_MOD];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_q <= 1'b0;
      end else if (ce) begin
         wdt_q <= wdt_hit;
      end
   end

   // internal reset request only; no pin is driven from it
   assign wdt_reset = wdt_q;

   // level interrupt, held until software clears the flag
   wire [N-1:0] mod_irq = flag_q & eccf & imask_q[N-1:0];
   // overflow interrupt has its own mask bit
   wire ovf_irq = ovf_q & imask_q[CTRL_OVF_BIT];
   assign irq = (|mod_irq) | ovf_irq;

   // hsize unused: only whole-word transfers are supported
   wire unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:16]};
endmodule : counter_array

// ==== rtl/pin_edge_sync.sv ====
`timescale 1ns/1ps
module pin_edge_sync (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;

   // only s2 and s3 are looked at; s1 may be metastable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a level counts once s2 and s3 agree, so a one-cycle glitch is dropped
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   // one pulse per transition, and only while enabled
   assign rise = ce & s2_q & s3_q & ~lvl_q;
   assign fall = ce & ~s2_q & ~s3_q & lvl_q;
endmodule : pin_edge_sync
